//--- shared/rf_regs_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 200 MHz system clock
// Notes:   Included by package and design files
`ifndef RF_REGS_PARAMS_SVH
`define RF_REGS_PARAMS_SVH

// Register offsets
`define RF_OFS_SYNTH_CONTROL_0      8'h01
`define RF_OFS_GUARD_TAIL_FRAMING   8'h1F

// Framing register fields
`define RF_FRM_SPARE_HI             23
`define RF_FRM_SPARE_LO             8
`define RF_FRM_TAIL_HI              7
`define RF_FRM_TAIL_LO              5
`define RF_FRM_GUARD_EN             4
`define RF_FRM_GUARD_LEN_HI         3
`define RF_FRM_GUARD_LEN_LO         0
`define RF_FRM_RESET                24'h000077

// Synthesizer control fields
`define RF_SYN_SIGMA_DELTA          31
`define RF_SYN_DAC_OUT              30
`define RF_SYN_PFD_RESET            29
`define RF_SYN_XTAL_OFF_SW          28
`define RF_SYN_XTAL_SRC_SEL         27
`define RF_SYN_CAL_ENABLE           26
`define RF_SYN_FOFS_HI              25
`define RF_SYN_FOFS_LO              24
`define RF_SYN_DAC_CAL_SW           23
`define RF_SYN_DAC_CAL_SEL          22
`define RF_SYN_VCO_GAIN             21
`define RF_SYN_SKIP_RC              20
`define RF_SYN_OFFSET_CAL           19
`define RF_SYN_RESET                32'hE0200000
`define RF_SYN_WRITE_MASK           32'hFFFF9FFF

// Calibration trigger hold time
`define RF_CAL_HOLD_US              10
`define RF_CLK_PERIOD_PS            5000
`define RF_CAL_HOLD_CYC ((`RF_CAL_HOLD_US * 1000000 + `RF_CLK_PERIOD_PS - 1) / `RF_CLK_PERIOD_PS)
`define RF_CAL_CNT_W                11

`endif

//--- shared/rf_regs_pkg.sv
// Purpose: Types shared by the framing sequencer and register bank
// Assumes: Constants come from rf_regs_params.svh
// Notes:   Gray codes along idle, guard, body, tail
`include "rf_regs_params.svh"
package rf_regs_pkg;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'h0,
      SEQ_GUARD = 2'h1,
      SEQ_BODY  = 2'h3,
      SEQ_TAIL  = 2'h2
   } seq_state_t;

   typedef struct packed {
      seq_state_t state;
      logic [3:0] cnt;
      logic       guard_active;
      logic       tail_active;
      logic       tx_bit;
      logic       preamble_go;
      logic       done;
   } seq_regs_t;

   typedef struct packed {
      logic [23:0]              frm;
      logic [31:0]              syn;
      logic [31:0]              rdata;
      logic [2:0]               ce_sync;
      logic                     ce_level;
      logic [`RF_CAL_CNT_W-1:0] cal_cnt;
      logic                     cal_done;
      logic                     cal_start;
      logic [15:0]              spare;
      logic [9:0]               ana;
   } ctrl_state_t;

endpackage : rf_regs_pkg

//--- shared/frame_seq_if.sv
// Purpose: Carries framing settings and bit-sequencer status
// Assumes: Both ends on I_CLOCK
// Notes:   ctrl end is the register bank
`timescale 1ns/1ps
interface frame_seq_if;
   logic       clk_en;
   logic       guard_en;
   logic [3:0] guard_len;
   logic [2:0] tail_cnt;
   logic       start;
   logic       crc_done;
   logic       last_bit;
   logic       tick;
   logic       guard_active;
   logic       tail_active;
   logic       tx_bit;
   logic       preamble_go;
   logic       done;

   modport ctrl (output clk_en, guard_en, guard_len, tail_cnt, start, crc_done, last_bit, tick,
                 input  guard_active, tail_active, tx_bit, preamble_go, done);
   modport seq  (input  clk_en, guard_en, guard_len, tail_cnt, start, crc_done, last_bit, tick,
                 output guard_active, tail_active, tx_bit, preamble_go, done);
endinterface : frame_seq_if

//--- design/frame_bit_seq.sv
// Purpose: Guard bits before the preamble and repeated tail bits after the CRC
// Assumes: tick marks one bit time; start, crc_done are one-cycle pulses
// Notes:   Guard bits alternate starting with 1
`timescale 1ns/1ps
`include "rf_regs_params.svh"
module frame_bit_seq
   import rf_regs_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rst,
   frame_seq_if.seq  fs
);
   seq_regs_t st;
   seq_regs_t next_st;

   always_comb begin
      next_st = st;
      next_st.preamble_go = 1'b0;
      next_st.done = 1'b0;
      case (st.state)
         SEQ_IDLE: begin
            if (fs.start) begin
               if (fs.guard_en) begin
                  next_st.state = SEQ_GUARD; // [RULE_02]
                  next_st.cnt = fs.guard_len; // [RULE_03]
                  next_st.guard_active = 1'b1;
                  next_st.tx_bit = 1'b1;
               end else begin
                  next_st.state = SEQ_BODY; // [RULE_02]
                  next_st.preamble_go = 1'b1;
               end
            end
         end
         SEQ_GUARD: begin
            if (fs.tick) begin
               next_st.tx_bit = ~st.tx_bit;
               if (st.cnt == 4'h0) begin
                  next_st.state = SEQ_BODY; // [RULE_03]
                  next_st.guard_active = 1'b0;
                  next_st.preamble_go = 1'b1;
                  next_st.tx_bit = 1'b0;
               end else begin
                  next_st.cnt = st.cnt - 4'h1;
               end
            end
         end
         SEQ_BODY: begin
            if (fs.crc_done) begin
               if (fs.tail_cnt == 3'h0) begin
                  next_st.state = SEQ_IDLE; // [RULE_01]
                  next_st.done = 1'b1;
               end else begin
                  next_st.state = SEQ_TAIL;
                  next_st.cnt = {1'b0, fs.tail_cnt - 3'h1}; // [RULE_01]
                  next_st.tail_active = 1'b1;
                  next_st.tx_bit = fs.last_bit;
               end
            end
         end
         SEQ_TAIL: begin
            if (fs.tick) begin
               if (st.cnt == 4'h0) begin
                  next_st.state = SEQ_IDLE; // [RULE_01]
                  next_st.tail_active = 1'b0;
                  next_st.tx_bit = 1'b0;
                  next_st.done = 1'b1;
               end else begin
                  next_st.cnt = st.cnt - 4'h1;
               end
            end
         end
         default: begin
            next_st.state = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st <= '0;
      end else if (fs.clk_en) begin
         st <= next_st;
      end
   end

   assign fs.guard_active = st.guard_active;
   assign fs.tail_active  = st.tail_active;
   assign fs.tx_bit       = st.tx_bit;
   assign fs.preamble_go  = st.preamble_go;
   assign fs.done         = st.done;

   // Bit counters seen only by the checks
   logic [4:0] guard_bits;
   logic [3:0] tail_bits;
   always_ff @(posedge i_clk) begin
      if (i_rst || (fs.clk_en && st.state == SEQ_IDLE)) begin
         guard_bits <= 5'h0;
         tail_bits  <= 4'h0;
      end else if (fs.clk_en && fs.tick) begin
         if (st.state == SEQ_GUARD) begin
            guard_bits <= guard_bits + 5'h1;
         end
         if (st.state == SEQ_TAIL) begin
            tail_bits <= tail_bits + 4'h1;
         end
      end
   end

   AST_GUARD_BYPASS: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_02]
      (fs.clk_en && st.state == SEQ_IDLE && fs.start && !fs.guard_en)
      |=> (st.preamble_go && !st.guard_active))
      else $error("Guard inserted while disabled");
   AST_GUARD_LENGTH: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_03]
      (fs.clk_en && st.state == SEQ_GUARD && fs.tick && st.cnt == 4'h0)
      |-> (guard_bits + 5'h1 == {1'b0, fs.guard_len} + 5'h1))
      else $error("Guard bit count is not length plus one");
   AST_TAIL_LENGTH: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_01]
      (fs.clk_en && st.state == SEQ_TAIL && fs.tick && st.cnt == 4'h0)
      |-> (tail_bits + 4'h1 == {1'b0, fs.tail_cnt}))
      else $error("Tail repeat count mismatch");
   AST_NO_TAIL: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_01]
      (fs.clk_en && st.state == SEQ_BODY && fs.crc_done && fs.tail_cnt == 3'h0)
      |=> (!st.tail_active && st.done))
      else $error("Tail sent with zero count");
   COV_GUARD_FRAME: cover property (@(posedge i_clk) disable iff (i_rst)
      st.state == SEQ_GUARD ##[1:64] st.preamble_go);
   COV_TAIL_FRAME: cover property (@(posedge i_clk) disable iff (i_rst)
      st.tail_active ##[1:64] st.done);

endmodule : frame_bit_seq

//--- design/radio_frame_pll_ctrl_regs.sv
// Purpose: Framing and synthesizer control register pair with field outputs
// Assumes: Plain register port at printed offsets; read data one cycle later
// Notes:   I_CLK_EN low freezes all state; reset wins over it
//
// Contract
// [RULE_01] Tail count bits 7:5, reset 3, repeats that many tail bits after CRC.
// [RULE_02] Guard enable bit 4, reset 1, guard bits inserted only when set.
// [RULE_03] Guard length bits 3:0, reset 7, sends value plus one guard bits.
// [RULE_04] Spare field bits 23:8, reset zero, driven straight to analogue.
// [RULE_05] Bit 31 enables sigma-delta modulator, reset value 1.
// [RULE_06] Bit 26 set: start calibration after chip enable high 10 us.
// [RULE_07] Bit 27 set: crystal off from bit 28; else from state machine.
// [RULE_08] DAC calibration on per effective enable; register bit 23 resets 0.
// [RULE_09] Bit 22 selects DAC calibration enable source: register or state machine.
// [RULE_10] Bit 21 one gives normal VCO gain, zero gives five times.
// [RULE_11] Bit 20 set skips calibration RC phase; reset 0 runs it.
// [RULE_12] Offset calibration follows register enable bit 19, reset 0.
// [RULE_13] Fields reach outputs edge after write; reads return stored; reset loads.
// [RULE_14] Bits 30, 29 and 25:24 driven as stored, resets 1, 1, 0.
`timescale 1ns/1ps
`include "rf_regs_params.svh"
module radio_frame_pll_ctrl_regs
   import rf_regs_pkg::*;
#(
   parameter int CAL_HOLD_CYC = `RF_CAL_HOLD_CYC
)
(
   input  wire logic        I_CLOCK,
   input  wire logic        I_RST,
   input  wire logic        I_CLK_EN,
   input  wire logic [7:0]  I_ADDR,
   input  wire logic [31:0] I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic      [31:0] O_RDATA,
   input  wire logic        I_CHIP_ENABLE,
   input  wire logic        I_XTAL_OFF_FSM,
   input  wire logic        I_DAC_CAL_FSM,
   input  wire logic        I_FRAME_START,
   input  wire logic        I_CRC_DONE,
   input  wire logic        I_LAST_BIT,
   input  wire logic        I_BIT_TICK,
   output logic             O_GUARD_ACTIVE,
   output logic             O_TAIL_ACTIVE,
   output logic             O_TX_BIT,
   output logic             O_PREAMBLE_GO,
   output logic             O_FRAME_DONE,
   output logic      [15:0] O_SPARE,
   output logic             O_SIGMA_DELTA_EN,
   output logic             O_DAC_OUT_EN,
   output logic             O_PHASE_DETECTOR_RESET_CTL,
   output logic      [1:0]  O_FREQ_OFFSET_SELECT,
   output logic             O_XTAL_OFF,
   output logic             O_CAL_START,
   output logic             O_DAC_CAL_EN,
   output logic             O_VCO_GAIN_NORMAL,
   output logic             O_SKIP_RC_PHASE,
   output logic             O_OFFSET_CAL_EN
);
   localparam logic [`RF_CAL_CNT_W-1:0] CAL_LAST = (`RF_CAL_CNT_W)'(CAL_HOLD_CYC - 1);

   // Analogue bundle positions
   localparam int A_SDM  = 9;
   localparam int A_DAC  = 8;
   localparam int A_PFD  = 7;
   localparam int A_FOH  = 6;
   localparam int A_FOL  = 5;
   localparam int A_XTAL = 4;
   localparam int A_DCAL = 3;
   localparam int A_VCO  = 2;
   localparam int A_SKIP = 1;
   localparam int A_OCAL = 0;

   ctrl_state_t st;
   ctrl_state_t next_st;

   // Picks register value or state-machine value by source select
   function automatic logic pick_source(input logic sel, input logic sw, input logic fsm);
      pick_source = sel ? sw : fsm;
   endfunction : pick_source

   // Register address decode
   function automatic logic hit_framing(input logic [7:0] a);
      hit_framing = (a == `RF_OFS_GUARD_TAIL_FRAMING);
   endfunction : hit_framing

   function automatic logic hit_synth(input logic [7:0] a);
      hit_synth = (a == `RF_OFS_SYNTH_CONTROL_0);
   endfunction : hit_synth

   always_comb begin
      next_st = st;
      next_st.rdata = 32'h00000000;
      // Register writes
      if (I_WR) begin
         if (hit_framing(I_ADDR)) begin
            next_st.frm = I_WDATA[23:0]; // [RULE_13]
         end else if (hit_synth(I_ADDR)) begin
            next_st.syn = I_WDATA & `RF_SYN_WRITE_MASK; // [RULE_13]
         end
      end
      // Register reads, answer in the next cycle only
      if (I_RD) begin
         if (hit_framing(I_ADDR)) begin
            next_st.rdata = {8'h00, st.frm}; // [RULE_13]
         end else if (hit_synth(I_ADDR)) begin
            next_st.rdata = st.syn; // [RULE_13]
         end
      end
      // Chip enable pin filter
      next_st.ce_sync = {st.ce_sync[1:0], I_CHIP_ENABLE};
      if (st.ce_sync[2] == st.ce_sync[1]) begin
         next_st.ce_level = st.ce_sync[2];
      end
      // Calibration trigger after hold time
      next_st.cal_start = 1'b0;
      if (!st.ce_level || !st.syn[`RF_SYN_CAL_ENABLE]) begin
         next_st.cal_cnt = '0; // [RULE_06]
         next_st.cal_done = 1'b0;
      end else if (!st.cal_done) begin
         if (st.cal_cnt == CAL_LAST) begin
            next_st.cal_start = 1'b1; // [RULE_06]
            next_st.cal_done = 1'b1;
         end else begin
            next_st.cal_cnt = st.cal_cnt + 1'b1;
         end
      end
      // Field outputs, one edge after the stored value
      next_st.spare = st.frm[`RF_FRM_SPARE_HI:`RF_FRM_SPARE_LO]; // [RULE_04]
      next_st.ana[A_SDM] = st.syn[`RF_SYN_SIGMA_DELTA]; // [RULE_05]
      next_st.ana[A_DAC] = st.syn[`RF_SYN_DAC_OUT]; // [RULE_14]
      next_st.ana[A_PFD] = st.syn[`RF_SYN_PFD_RESET]; // [RULE_14]
      next_st.ana[A_FOH:A_FOL] = st.syn[`RF_SYN_FOFS_HI:`RF_SYN_FOFS_LO]; // [RULE_14]
      next_st.ana[A_XTAL] = pick_source(st.syn[`RF_SYN_XTAL_SRC_SEL],
                                        st.syn[`RF_SYN_XTAL_OFF_SW], I_XTAL_OFF_FSM); // [RULE_07]
      next_st.ana[A_DCAL] = pick_source(st.syn[`RF_SYN_DAC_CAL_SEL], // [RULE_09]
                                        st.syn[`RF_SYN_DAC_CAL_SW], I_DAC_CAL_FSM); // [RULE_08]
      next_st.ana[A_VCO] = st.syn[`RF_SYN_VCO_GAIN]; // [RULE_10]
      next_st.ana[A_SKIP] = st.syn[`RF_SYN_SKIP_RC]; // [RULE_11]
      next_st.ana[A_OCAL] = st.syn[`RF_SYN_OFFSET_CAL]; // [RULE_12]
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
         st <= '0;
         st.frm <= `RF_FRM_RESET; // [RULE_13]
         st.syn <= `RF_SYN_RESET; // [RULE_13]
         st.ana <= 10'h384;
      end else if (I_CLK_EN) begin
         st <= next_st;
      end
   end

   // Framing sequencer
   frame_seq_if fs ();
   assign fs.clk_en    = I_CLK_EN;
   assign fs.guard_en  = st.frm[`RF_FRM_GUARD_EN]; // [RULE_02]
   assign fs.guard_len = st.frm[`RF_FRM_GUARD_LEN_HI:`RF_FRM_GUARD_LEN_LO]; // [RULE_03]
   assign fs.tail_cnt  = st.frm[`RF_FRM_TAIL_HI:`RF_FRM_TAIL_LO]; // [RULE_01]
   assign fs.start     = I_FRAME_START;
   assign fs.crc_done  = I_CRC_DONE;
   assign fs.last_bit  = I_LAST_BIT;
   assign fs.tick      = I_BIT_TICK;

   frame_bit_seq u_seq (
      .i_clk (I_CLOCK),
      .i_rst (I_RST),
      .fs    (fs.seq)
   );

   assign O_GUARD_ACTIVE             = fs.guard_active;
   assign O_TAIL_ACTIVE              = fs.tail_active;
   assign O_TX_BIT                   = fs.tx_bit;
   assign O_PREAMBLE_GO              = fs.preamble_go;
   assign O_FRAME_DONE               = fs.done;
   assign O_RDATA                    = st.rdata;
   assign O_SPARE                    = st.spare;
   assign O_SIGMA_DELTA_EN           = st.ana[A_SDM];
   assign O_DAC_OUT_EN               = st.ana[A_DAC];
   assign O_PHASE_DETECTOR_RESET_CTL = st.ana[A_PFD];
   assign O_FREQ_OFFSET_SELECT       = st.ana[A_FOH:A_FOL];
   assign O_XTAL_OFF                 = st.ana[A_XTAL];
   assign O_DAC_CAL_EN               = st.ana[A_DCAL];
   assign O_VCO_GAIN_NORMAL          = st.ana[A_VCO];
   assign O_SKIP_RC_PHASE            = st.ana[A_SKIP];
   assign O_OFFSET_CAL_EN            = st.ana[A_OCAL];
   assign O_CAL_START                = st.cal_start;

   // Checks
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RST);

   AST_SDM_FOLLOWS: assert property ( // [RULE_05]
      $past(I_CLK_EN) |-> O_SIGMA_DELTA_EN == $past(st.syn[`RF_SYN_SIGMA_DELTA]))
      else $error("Sigma-delta enable does not follow register");
   AST_XTAL_SOURCE: assert property ( // [RULE_07]
      $past(I_CLK_EN) |-> O_XTAL_OFF == ($past(st.syn[`RF_SYN_XTAL_SRC_SEL])
         ? $past(st.syn[`RF_SYN_XTAL_OFF_SW]) : $past(I_XTAL_OFF_FSM)))
      else $error("Crystal power-down source wrong");
   AST_DAC_CAL_SOURCE: assert property ( // [RULE_09]
      $past(I_CLK_EN) |-> O_DAC_CAL_EN == ($past(st.syn[`RF_SYN_DAC_CAL_SEL])
         ? $past(st.syn[`RF_SYN_DAC_CAL_SW]) : $past(I_DAC_CAL_FSM)))
      else $error("DAC calibration source wrong");
   AST_VCO_SKIP_OCAL: assert property ( // [RULE_10]
      $past(I_CLK_EN) |-> {O_VCO_GAIN_NORMAL, O_SKIP_RC_PHASE, O_OFFSET_CAL_EN}
         == $past(st.syn[`RF_SYN_VCO_GAIN:`RF_SYN_OFFSET_CAL]))
      else $error("VCO gain, RC skip or offset calibration mismatch");
   AST_ANALOG_DIRECT: assert property ( // [RULE_14]
      $past(I_CLK_EN) |-> {O_DAC_OUT_EN, O_PHASE_DETECTOR_RESET_CTL, O_FREQ_OFFSET_SELECT}
         == {$past(st.syn[`RF_SYN_DAC_OUT]), $past(st.syn[`RF_SYN_PFD_RESET]),
             $past(st.syn[`RF_SYN_FOFS_HI:`RF_SYN_FOFS_LO])})
      else $error("Direct synthesizer outputs mismatch");
   AST_SPARE_WRITE: assert property ( // [RULE_04]
      (I_CLK_EN && I_WR && hit_framing(I_ADDR)) ##1 I_CLK_EN
      |=> O_SPARE == $past(I_WDATA[`RF_FRM_SPARE_HI:`RF_FRM_SPARE_LO], 2))
      else $error("Spare output not written value");
   AST_READBACK: assert property ( // [RULE_13]
      (I_CLK_EN && I_WR && !I_RD && hit_synth(I_ADDR))
      ##1 (I_CLK_EN && I_RD && hit_synth(I_ADDR))
      |=> O_RDATA == ($past(I_WDATA, 2) & `RF_SYN_WRITE_MASK))
      else $error("Synthesizer register readback wrong");
   AST_READ_ONE_CYCLE: assert property ( // [RULE_13]
      (I_CLK_EN && !I_RD) |=> O_RDATA == 32'h00000000)
      else $error("Read data held beyond one cycle");
   AST_CAL_GATED: assert property ( // [RULE_06]
      $rose(O_CAL_START) |-> $past(st.syn[`RF_SYN_CAL_ENABLE]) && $past(st.cal_cnt) == CAL_LAST)
      else $error("Calibration started without enable or full hold");
   AST_CAL_PULSE: assert property ( // [RULE_06]
      (O_CAL_START && I_CLK_EN) |=> !O_CAL_START)
      else $error("Calibration start longer than one cycle");

   AST_RESET_REGS: assert property ( // [RULE_13]
      $past(I_RST)
      |-> st.frm == `RF_FRM_RESET && st.syn == `RF_SYN_RESET)
      else $error("Register reset values wrong");

   AST_RESET_DIRECT: assert property ( // [RULE_14]
      $past(I_RST)
      |-> {O_DAC_OUT_EN, O_PHASE_DETECTOR_RESET_CTL, O_FREQ_OFFSET_SELECT} == 4'hC)
      else $error("Direct outputs not at reset");

   AST_RESET_SYNTH_OUT: assert property ( // [RULE_05]
      $past(I_RST)
      |-> O_SIGMA_DELTA_EN && O_VCO_GAIN_NORMAL && !O_SKIP_RC_PHASE && !O_OFFSET_CAL_EN)
      else $error("Synthesizer outputs not at reset");

   AST_RESET_BUS: assert property ( // [RULE_04]
      $past(I_RST)
      |-> O_RDATA == 32'h00000000 && O_SPARE == 16'h0000)
      else $error("Read data or spare not cleared");

   AST_FREEZE: assert property ( // [RULE_13]
      $past(!I_RST && !I_CLK_EN)
      |-> $stable(st))
      else $error("State moved with enable low");

   AST_WRITE_FRAMING: assert property ( // [RULE_13]
      (I_CLK_EN && I_WR && hit_framing(I_ADDR))
      |=> st.frm == $past(I_WDATA[`RF_FRM_SPARE_HI:0]))
      else $error("Framing write not stored");

   AST_WRITE_SYNTH: assert property ( // [RULE_13]
      (I_CLK_EN && I_WR && hit_synth(I_ADDR))
      |=> st.syn == ($past(I_WDATA) & `RF_SYN_WRITE_MASK))
      else $error("Synthesizer write not stored");

   AST_WRITE_REFUSED: assert property ( // [RULE_13]
      (I_CLK_EN && I_WR && !hit_framing(I_ADDR) && !hit_synth(I_ADDR))
      |=> $stable(st.frm) && $stable(st.syn))
      else $error("Unmapped write changed a register");

   AST_READ_FRAMING: assert property ( // [RULE_13]
      (I_CLK_EN && I_RD && hit_framing(I_ADDR))
      |=> O_RDATA == {8'h00, $past(st.frm)})
      else $error("Framing readback wrong");

   AST_READ_REFUSED: assert property ( // [RULE_13]
      (I_CLK_EN && I_RD && !hit_framing(I_ADDR) && !hit_synth(I_ADDR))
      |=> O_RDATA == 32'h00000000)
      else $error("Unmapped read not zero");

   AST_CAL_OFF: assert property ( // [RULE_06]
      (I_CLK_EN && !st.syn[`RF_SYN_CAL_ENABLE])
      |=> !O_CAL_START)
      else $error("Calibration started while disabled");

   AST_CAL_RESTART: assert property ( // [RULE_06]
      (I_CLK_EN && !st.ce_level)
      |=> st.cal_cnt == '0 && !st.cal_done)
      else $error("Calibration count kept");

   AST_CE_HOLD: assert property ( // [RULE_06]
      (I_CLK_EN && st.ce_sync[2] != st.ce_sync[1])
      |=> $stable(st.ce_level))
      else $error("Chip enable moved early");

   AST_CE_FOLLOW: assert property ( // [RULE_06]
      (I_CLK_EN && st.ce_sync[2] == st.ce_sync[1])
      |=> st.ce_level == $past(st.ce_sync[2]))
      else $error("Chip enable missed agreeing flops");

   COV_CAL: cover property ($rose(O_CAL_START));
   COV_XTAL_SW: cover property (st.syn[`RF_SYN_XTAL_SRC_SEL] && O_XTAL_OFF);
   COV_READ: cover property (I_CLK_EN && I_RD ##1 O_RDATA != 32'h00000000);

endmodule : radio_frame_pll_ctrl_regs

//--- verif/rf_front_model.sv
// Purpose: Front-end model giving bit ticks and state machine levels
// Assumes: One tick every TICK_DIV cycles, silent in reset
// Notes:   Levels follow bench commands one edge later
`timescale 1ns/1ps
module rf_front_model #(
   parameter int TICK_DIV = 3
)
(
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_xtal_lvl,
   input  wire logic i_dac_lvl,
   output logic      o_tick,
   output logic      o_xtal_off_fsm,
   output logic      o_dac_cal_fsm
);
   int div;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         div            <= 0;
         o_tick         <= 1'b0;
         o_xtal_off_fsm <= 1'b0;
         o_dac_cal_fsm  <= 1'b0;
      end else begin
         div            <= (div == TICK_DIV - 1) ? 0 : div + 1;
         o_tick         <= (div == TICK_DIV - 1);
         o_xtal_off_fsm <= i_xtal_lvl;
         o_dac_cal_fsm  <= i_dac_lvl;
      end
   end
endmodule : rf_front_model

//--- verif/radio_frame_pll_ctrl_regs_tb.sv
// Purpose: Self-checking bench for the framing and synthesizer registers
// Assumes: Calibration hold shortened to 8 cycles
// Notes:   Front-end model supplies ticks and state machine levels
`timescale 1ns/1ps
module radio_frame_pll_ctrl_regs_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        ce = 1'b0;
   logic        start = 1'b0;
   logic        crc = 1'b0;
   logic        last = 1'b0;
   logic        xtal_lvl = 1'b0;
   logic        dac_lvl = 1'b0;
   logic [31:0] rdata;
   logic [15:0] spare;
   logic [1:0]  fofs;
   logic        tick, xtal_fsm, dac_fsm, g_act, t_act, tx, go, done, cal;
   logic        sd, dac_out, pfd, xtal, dac_cal, vco, skip, ofs;
   int          n_fail = 0;
   int          checks = 0;
   int          n_guard, n_tail, n_ones, n_go, n_done, n_cal;

   always #2.5 clk = ~clk;

   rf_front_model u_rf_front_model (.i_clk(clk), .i_rst(rst), .i_xtal_lvl(xtal_lvl),
      .i_dac_lvl(dac_lvl), .o_tick(tick), .o_xtal_off_fsm(xtal_fsm), .o_dac_cal_fsm(dac_fsm));

   radio_frame_pll_ctrl_regs #(.CAL_HOLD_CYC(8)) u_radio_frame_pll_ctrl_regs (
      .I_CLOCK(clk), .I_RST(rst), .I_CLK_EN(clk_en), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CHIP_ENABLE(ce), .I_XTAL_OFF_FSM(xtal_fsm),
      .I_DAC_CAL_FSM(dac_fsm), .I_FRAME_START(start), .I_CRC_DONE(crc), .I_LAST_BIT(last),
      .I_BIT_TICK(tick), .O_GUARD_ACTIVE(g_act), .O_TAIL_ACTIVE(t_act), .O_TX_BIT(tx),
      .O_PREAMBLE_GO(go), .O_FRAME_DONE(done), .O_SPARE(spare), .O_SIGMA_DELTA_EN(sd),
      .O_DAC_OUT_EN(dac_out), .O_PHASE_DETECTOR_RESET_CTL(pfd), .O_FREQ_OFFSET_SELECT(fofs),
      .O_XTAL_OFF(xtal), .O_CAL_START(cal), .O_DAC_CAL_EN(dac_cal), .O_VCO_GAIN_NORMAL(vco),
      .O_SKIP_RC_PHASE(skip), .O_OFFSET_CAL_EN(ofs));

   // Event counters sampled at each edge
   always @(posedge clk) begin
      if (g_act === 1'b1 && tick === 1'b1) n_guard++;
      if (t_act === 1'b1 && tick === 1'b1) n_tail++;
      if (t_act === 1'b1 && tick === 1'b1 && tx === 1'b1) n_ones++;
      if (go === 1'b1) n_go++;
      if (done === 1'b1) n_done++;
      if (cal === 1'b1) n_cal++;
   end

   function automatic logic [31:0] outs();
      return {22'h0, sd, dac_out, pfd, fofs, xtal, dac_cal, vco, skip, ofs};
   endfunction : outs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : reg_rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic t_reset();
      reg_rd(8'h1F, 32'h00000077);
      reg_rd(8'h01, 32'hE0200000);
      chk(outs(), 32'h384);
      chk({16'h0, spare}, 32'h0);
   endtask : t_reset

   task automatic t_regs();
      reg_wr(8'h1F, 32'hFFABCD51);
      settle(1);
      chk({16'h0, spare}, 32'h0000ABCD);
      reg_rd(8'h1F, 32'h00ABCD51);
      reg_wr(8'h01, 32'h5AD865A5);
      settle(1);
      chk(outs(), 32'h15B);
      reg_rd(8'h01, 32'h5AD805A5);
      reg_wr(8'h01, 32'h10800000);
      xtal_lvl <= 1'b1;
      dac_lvl  <= 1'b1;
      settle(3);
      chk(outs(), 32'h018);
      xtal_lvl <= 1'b0;
      dac_lvl  <= 1'b0;
      settle(3);
      chk(outs(), 32'h000);
   endtask : t_regs

   task automatic t_refuse();
      reg_rd(8'h02, 32'h0);
      reg_wr(8'h02, 32'hFFFFFFFF);
      @(posedge clk);
      clk_en <= 1'b0;
      reg_wr(8'h01, 32'h0);
      @(posedge clk);
      clk_en <= 1'b1;
      reg_rd(8'h01, 32'h10800000);
   endtask : t_refuse

   task automatic t_frame(input logic [31:0] cfg, input int ng, input int nt);
      reg_wr(8'h1F, cfg);
      n_guard = 0;
      n_tail  = 0;
      n_ones  = 0;
      n_go    = 0;
      n_done  = 0;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (int i = 0; i < 300 && n_go == 0; i++) @(negedge clk);
      @(posedge clk);
      crc  <= 1'b1;
      last <= 1'b1;
      @(posedge clk);
      crc  <= 1'b0;
      for (int i = 0; i < 300 && n_done == 0; i++) @(negedge clk);
      settle(2);
      chk(n_guard, ng);
      chk(n_go, 1);
      chk(n_tail, nt);
      chk(n_ones, nt);
      chk(n_done, 1);
   endtask : t_frame

   task automatic t_cal(input logic [31:0] syn, input int exp);
      reg_wr(8'h01, syn);
      n_cal = 0;
      @(posedge clk);
      ce <= 1'b1;
      settle(8);
      chk(n_cal, 0);
      settle(40);
      chk(n_cal, exp);
      ce <= 1'b0;
      settle(10);
   endtask : t_cal

   task automatic summarize();
      if (n_fail == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_refuse();
      t_frame(32'h00ABCD51, 2, 2);
      t_frame(32'h000000FF, 16, 7);
      t_frame(32'h0000000F, 0, 0);
      t_cal(32'hE4200000, 1);
      t_cal(32'hE0200000, 0);
      summarize();
   end

   initial begin
      #20000;
      n_fail++;
      summarize();
   end
endmodule : radio_frame_pll_ctrl_regs_tb
